// ==== src/fio_map.vh ====
`ifndef FIO_MAP_VH
`define FIO_MAP_VH
// register byte offsets on the axi4-lite slave
`define FIO_OFF_FORCE_SELECT 8'h00
`define FIO_OFF_FORCED_IN 8'h04
`define FIO_OFF_IN_MONITOR 8'h08
`define FIO_OFF_FORCED_OUT 8'h0c
`define FIO_OFF_OUT_MONITOR 8'h10
`define FIO_OFF_IN_POLARITY 8'h14
`define FIO_OFF_OUT_POLARITY 8'h18
`define FIO_OFF_VIRT_IN 8'h1c
`define FIO_OFF_VIRT_EN 8'h20
// field widths and positions
`define FIO_NUM_IN 9
`define FIO_NUM_OUT 5
`define FIO_SEL_IN_BIT 0
`define FIO_SEL_OUT_BIT 1
// reset values
`define FIO_RST_SELECT 2'h0
`define FIO_RST_IN 9'h000
`define FIO_RST_OUT 5'h00
`define FIO_RST_ADDR 8'h00
`define FIO_RST_WORD 32'h00000000
`define FIO_RST_STRB 4'h0
// axi responses
`define FIO_RESP_OKAY 2'h0
`define FIO_RESP_SLVERR 2'h2
`endif

// ==== src/fio_override.v ====
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "fio_map.vh"

// Functional notes
// - input forcing replaces all input pin levels
// - select 0 none,1 in,2 out,3 both
// - forced input bit i sets terminal i
// - input polarity applies to forced levels too
// - output forcing overrides allocated output functions
// - forced output bit i marks function valid
// - pin level is validity combined with polarity
// - input monitor reports current input levels
// - output monitor reports five actual pin levels
// - select cleared at reset, zero restores normal
// - forcing also replaces virtual communication inputs
module fio_override (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [8:0] in_pins,
  output reg [8:0] in_func_valid,
  input wire [4:0] out_func_valid,
  output reg [4:0] out_pins
);

  // register storage
  reg [1:0] force_select_r;
  reg [8:0] forced_input_levels_r;
  reg [4:0] forced_output_validity_r;
  reg [8:0] in_pol_r;
  reg [4:0] out_pol_r;
  reg [8:0] virt_in_r;
  reg [8:0] virt_en_r;
  reg [8:0] in_s1_r;
  reg [8:0] in_s2_r;
  reg [8:0] in_s3_r;
  reg [8:0] in_hold_r;
  reg [8:0] in_lvl_r;
  reg [8:0] in_lvl_nxt;
  reg [4:0] out_nxt;
  reg [7:0] awaddr_r;
  reg aw_have_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_have_r;
  wire wr_go;
  wire rd_go;
  wire force_in;
  wire force_out;
  wire [7:0] aw_word;
  wire [7:0] ar_word;
  // per-terminal filtered level and function validity
  wire [8:0] in_filt;
  wire [8:0] in_func_nxt;
  genvar g;

  // returns 1 when a byte offset names a register
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `FIO_OFF_FORCE_SELECT) || (a == `FIO_OFF_FORCED_IN) ||
        (a == `FIO_OFF_IN_MONITOR) || (a == `FIO_OFF_FORCED_OUT) ||
        (a == `FIO_OFF_OUT_MONITOR) || (a == `FIO_OFF_IN_POLARITY) ||
        (a == `FIO_OFF_OUT_POLARITY) || (a == `FIO_OFF_VIRT_IN) ||
        (a == `FIO_OFF_VIRT_EN);
    end
  endfunction

  // clears the byte-in-word bits; every register is one whole word,
  // so a byte address inside a word reaches the same register
  // rather than an unmapped slot
  function [7:0] word_of;
    input [7:0] a;
    begin
      word_of = {a[7:2], 2'b00};
    end
  endfunction

  // select decode takes effect in the same cycle as the write lands
  assign force_in = force_select_r[`FIO_SEL_IN_BIT];
  assign force_out = force_select_r[`FIO_SEL_OUT_BIT];

  // address and data are latched independently, in either order;
  // readiness is withdrawn while ce is low, so the master never sees
  // a handshake on an edge at which the slave is frozen
  assign s_axi_awready = ce & ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready = ce & ~w_have_r & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  // word addresses shared by the write and read decoders
  assign aw_word = word_of(awaddr_r);
  assign ar_word = word_of(s_axi_araddr);

  // input level: forced word wins over pins and virtual inputs
  always @* begin
    if (force_in) begin
      in_lvl_nxt = forced_input_levels_r;
    end else begin
      // virtual bits replace filtered pin bits where enabled
      in_lvl_nxt = (in_filt & ~virt_en_r) | (virt_in_r & virt_en_r);
    end
  end

  // output pins: validity xnor high-active polarity bit
  always @* begin
    if (force_out) begin
      out_nxt = ~(forced_output_validity_r ^ out_pol_r);
    end else begin
      out_nxt = ~(out_func_valid ^ out_pol_r);
    end
  end

  // one filter and one polarity stage per terminal; a bit only moves
  // once stages two and three agree, so a level caught mid-change by
  // the first stage cannot flicker into the functions
  generate
    for (g = 0; g < `FIO_NUM_IN; g = g + 1) begin : g_term
      assign in_filt[g] = (in_s2_r[g] == in_s3_r[g]) ? in_s3_r[g] :
        in_hold_r[g];
      // valid when the level, forced or not, matches its active level
      assign in_func_nxt[g] = ~(in_lvl_nxt[g] ^ in_pol_r[g]);
    end
  endgenerate

  // pin synchroniser; a bit counts once stages two and three agree
  always @(posedge clk) begin
    if (!nrst) begin
      in_s1_r <= `FIO_RST_IN;
      in_s2_r <= `FIO_RST_IN;
      in_s3_r <= `FIO_RST_IN;
      in_hold_r <= `FIO_RST_IN;
    end else if (ce) begin
      in_s1_r <= in_pins;
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
      in_hold_r <= in_filt; // last agreed level
    end
  end

  // polarity is applied after forcing, so forced bits behave like pins
  always @(posedge clk) begin
    if (!nrst) begin
      in_lvl_r <= `FIO_RST_IN;
      in_func_valid <= `FIO_RST_IN;
      out_pins <= `FIO_RST_OUT;
    end else if (ce) begin
      in_lvl_r <= in_lvl_nxt;
      in_func_valid <= in_func_nxt;
      out_pins <= out_nxt;
    end
  end

  // write side: latch channels, then commit both
  always @(posedge clk) begin
    if (!nrst) begin
      force_select_r <= `FIO_RST_SELECT;
      forced_input_levels_r <= `FIO_RST_IN;
      forced_output_validity_r <= `FIO_RST_OUT;
      in_pol_r <= `FIO_RST_IN;
      out_pol_r <= `FIO_RST_OUT;
      virt_in_r <= `FIO_RST_IN;
      virt_en_r <= `FIO_RST_IN;
      awaddr_r <= `FIO_RST_ADDR;
      aw_have_r <= 1'b0;
      wdata_r <= `FIO_RST_WORD;
      wstrb_r <= `FIO_RST_STRB;
      w_have_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FIO_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_word) ?
          `FIO_RESP_OKAY : `FIO_RESP_SLVERR;
        // byte lane 0 holds bits 7:0, lane 1 holds bit 8; upper bits dropped
        case (aw_word)
          // a new select is decoded on the very next cycle, even running
          `FIO_OFF_FORCE_SELECT: begin
            if (wstrb_r[0]) begin
              force_select_r <= wdata_r[1:0];
            end
          end
          // bit 0 is the first input terminal
          `FIO_OFF_FORCED_IN: begin
            if (wstrb_r[0]) begin
              forced_input_levels_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
              forced_input_levels_r[8] <= wdata_r[8];
            end
          end
          // bit 0 is the first output terminal; bits 7:5 are dropped
          `FIO_OFF_FORCED_OUT: begin
            if (wstrb_r[0]) begin
              forced_output_validity_r <= wdata_r[4:0];
            end
          end
          // polarity 1 makes a terminal high active
          `FIO_OFF_IN_POLARITY: begin
            if (wstrb_r[0]) begin
              in_pol_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
              in_pol_r[8] <= wdata_r[8];
            end
          end
          // same encoding for the five output terminals
          `FIO_OFF_OUT_POLARITY: begin
            if (wstrb_r[0]) begin
              out_pol_r <= wdata_r[4:0];
            end
          end
          // virtual inputs stand in for pins bit by bit when enabled
          `FIO_OFF_VIRT_IN: begin
            if (wstrb_r[0]) begin
              virt_in_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
              virt_in_r[8] <= wdata_r[8];
            end
          end
          // forcing still wins over an enabled virtual input
          `FIO_OFF_VIRT_EN: begin
            if (wstrb_r[0]) begin
              virt_en_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
              virt_en_r[8] <= wdata_r[8];
            end
          end
          default: begin
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read side: one-cycle answer, monitors read live state
  always @(posedge clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `FIO_RST_WORD;
      s_axi_rresp <= `FIO_RESP_OKAY;
    end else if (ce) begin
      // the answer is registered on the same edge that takes the address
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(ar_word) ?
          `FIO_RESP_OKAY : `FIO_RESP_SLVERR;
        // monitors are copied here, so the output monitor lags out_pins by one cycle
        case (ar_word)
          `FIO_OFF_FORCE_SELECT: s_axi_rdata <= {30'h0, force_select_r};
          `FIO_OFF_FORCED_IN: s_axi_rdata <= {23'h0, forced_input_levels_r};
          `FIO_OFF_IN_MONITOR: s_axi_rdata <= {23'h0, in_lvl_r};
          `FIO_OFF_FORCED_OUT: begin
            s_axi_rdata <= {27'h0, forced_output_validity_r};
          end
          `FIO_OFF_OUT_MONITOR: s_axi_rdata <= {27'h0, out_pins};
          `FIO_OFF_IN_POLARITY: s_axi_rdata <= {23'h0, in_pol_r};
          `FIO_OFF_OUT_POLARITY: s_axi_rdata <= {27'h0, out_pol_r};
          `FIO_OFF_VIRT_IN: s_axi_rdata <= {23'h0, virt_in_r};
          `FIO_OFF_VIRT_EN: s_axi_rdata <= {23'h0, virt_en_r};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // fio_override

// ==== tb/fio_override_asserts.sv ====
`timescale 1ns/10ps
`include "fio_map.vh"
module fio_override_asserts (
  input logic clk, nrst, ce,
  input logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input logic s_axi_wready, s_axi_bvalid, s_axi_bready,
  input logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input logic s_axi_rready,
  input logic [7:0] s_axi_araddr,
  input logic [1:0] s_axi_bresp,
  input logic [31:0] s_axi_rdata,
  input logic [4:0] out_pins
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_b_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped early");
  chk_r_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read lost");
  chk_ar_gate: assert property (s_axi_arready == (ce && !s_axi_rvalid))
    else $error("arready wrong");
  chk_w_gate: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken during response");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready && ce ##1 ce |=> s_axi_bvalid)
    else $error("no write response");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready && ce
    |=> s_axi_rvalid) else $error("no read data");
  chk_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0
    || s_axi_bresp == 2'h2) else $error("bad write response");
  chk_ce_hold: assert property (!ce |=> $stable(out_pins))
    else $error("pins moved while frozen");
  chk_out_mon: assert property (
    s_axi_arvalid && s_axi_arready && ce
    && s_axi_araddr == `FIO_OFF_OUT_MONITOR
    |=> s_axi_rdata == {27'h0, $past(out_pins)})
    else $error("output monitor differs from pins");
endmodule // fio_override_asserts
bind fio_override fio_override_asserts u_chk (.clk(clk), .nrst(nrst),
  .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_araddr(s_axi_araddr), .s_axi_bresp(s_axi_bresp),
  .s_axi_rdata(s_axi_rdata), .out_pins(out_pins));

// ==== tb/fio_host.sv ====
`timescale 1ns/10ps
// host controller driving the drive's input terminals
module fio_host (
  input logic clk,
  input logic [8:0] level,
  output logic [8:0] in_pins = 9'h000
);
  // terminals switch on the clock, like a controller scan
  always @(posedge clk) in_pins <= level;
endmodule // fio_host

// ==== tb/fio_override_tb.sv ====
`timescale 1ns/10ps
`include "fio_map.vh"
module fio_override_tb;
  logic clk = 0, nrst = 0, ce = 1, ta, tw, tb;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [8:0] in_pins, in_func_valid, level = 9'h0aa;
  logic [4:0] out_pins, out_func_valid = 5'h00;
  integer num_errors = 0, comparisons = 0, n;
  // 50 mhz clock
  always #10 clk = ~clk;
  fio_override u_dut (.clk(clk), .nrst(nrst), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .in_pins(in_pins),
    .in_func_valid(in_func_valid), .out_func_valid(out_func_valid),
    .out_pins(out_pins));
  fio_host u_host (.clk(clk), .level(level), .in_pins(in_pins));
  task wrap_up;
    $display("counts: %0d compared, %0d wrong", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // a hung handshake counts as a mismatch and ends the run
  task fin(input ok);
    if (!ok) begin
      num_errors++;
      wrap_up;
    end
  endtask
  // inputs are sampled mid-cycle, so ready seen is the one at the edge
  task wr(input [7:0] a, input [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      n++;
    end while (!tb && n < 40);
    s_axi_bready <= 0;
    fin(tb);
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(negedge clk);
      ta = s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 0;
      n++;
    end while (!tb && n < 40);
    s_axi_rready <= 0;
    fin(tb);
  endtask
  task rc(input [7:0] a, input [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1;
    rc(`FIO_OFF_FORCE_SELECT, 32'h0);
    wr(`FIO_OFF_FORCED_IN, 32'hffff_ffff);
    rc(`FIO_OFF_FORCED_IN, 32'h1ff);
    wr(`FIO_OFF_FORCED_OUT, 32'hffff_ffff);
    rc(`FIO_OFF_FORCED_OUT, 32'h1f);
    $display("reset and width test done");
    // virtual inputs enabled too: forcing must still win
    wr(`FIO_OFF_VIRT_EN, 32'h1ff);
    wr(`FIO_OFF_FORCED_IN, 32'h1fe);
    wr(`FIO_OFF_FORCE_SELECT, 32'h1);
    rc(`FIO_OFF_IN_MONITOR, 32'h1fe);
    chk(in_func_valid, 32'h001);
    rc(`FIO_OFF_OUT_MONITOR, 32'h1f);
    $display("forced input test done");
    wr(`FIO_OFF_FORCED_OUT, 32'h1e);
    wr(`FIO_OFF_FORCE_SELECT, 32'h3);
    rc(`FIO_OFF_OUT_MONITOR, 32'h01);
    wr(`FIO_OFF_OUT_POLARITY, 32'h1f);
    @(negedge clk);
    chk(out_pins, 32'h1e);
    wr(`FIO_OFF_VIRT_EN, 32'h0);
    wr(`FIO_OFF_FORCE_SELECT, 32'h2);
    rc(`FIO_OFF_IN_MONITOR, 32'h0aa);
    rc(`FIO_OFF_OUT_MONITOR, 32'h1e);
    $display("forced output test done");
    out_func_valid <= 5'h15;
    wr(`FIO_OFF_FORCE_SELECT, 32'h0);
    rc(`FIO_OFF_OUT_MONITOR, 32'h15);
    chk(in_func_valid, 32'h155);
    // frozen pins must ignore a new function word until ce returns
    @(posedge clk);
    ce <= 0;
    out_func_valid <= 5'h0a;
    repeat (3) @(posedge clk);
    ce <= 1;
    @(negedge clk);
    chk(out_pins, 32'h15);
    rc(`FIO_OFF_OUT_MONITOR, 32'h0a);
    rd(8'h40);
    chk(r, `FIO_RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk(r, `FIO_RESP_SLVERR);
    wr(`FIO_OFF_FORCE_SELECT, 32'h3);
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    rc(`FIO_OFF_FORCE_SELECT, 32'h0);
    $display("release and reset test done");
    wrap_up;
  end
endmodule // fio_override_tb
